/* src/csr_defs.vh */
// register map, field positions and select codes for the counter routing block
// assumes a 32-bit apb slave with byte addresses on paddr[7:0]
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH

// per-counter register group, counter 1 sits one stride above counter 0
`define CSR_CTR_STRIDE   8'h20
`define CSR_R_CTRL       5'h00
`define CSR_R_SELA       5'h04
`define CSR_R_SELB       5'h08
`define CSR_R_LOAD       5'h0C
`define CSR_R_COUNT      5'h10
`define CSR_R_LATCH      5'h14
// shared registers
`define CSR_A_FT_LO      8'h40
`define CSR_A_FT_HI      8'h44
`define CSR_A_TRIG       8'h48
`define CSR_A_SQW        8'h4C
`define CSR_A_STATUS     8'h50

// counter control fields
`define CSR_C_ARM        0
`define CSR_C_HWEN       1
`define CSR_C_SRCFALL    2
`define CSR_C_DIR_LO     3
`define CSR_C_GATE_LO    5
`define CSR_C_TOGGLE     7
`define CSR_C_INVERT     8
`define CSR_C_GATEFALL   9
`define CSR_C_AUXEN      10
`define CSR_C_ZEN        11
`define CSR_CTRL_W       12
`define CSR_CTRL_RST     12'h000

// direction modes
`define CSR_DIR_UP       2'h0
`define CSR_DIR_DOWN     2'h1
`define CSR_DIR_BLVL     2'h2
`define CSR_DIR_AEDGE    2'h3
// gate actions
`define CSR_G_NONE       2'h0
`define CSR_G_START      2'h1
`define CSR_G_PAUSE      2'h2
`define CSR_G_LATCH      2'h3

// selector fields, six bits each
`define CSR_SEL_W        6
`define CSR_SA_SRC       0
`define CSR_SA_GATE      8
`define CSR_SA_AUX       16
`define CSR_SA_ARM       24
`define CSR_SB_A         0
`define CSR_SB_B         8
`define CSR_SB_Z         16
`define CSR_SELA_RST     32'h0000_0000
`define CSR_SELB_RST     32'h0000_0000
// codes 0..7 trigger lines, 8..23 function terminals, 24 and up specials
`define CSR_SEL_SPEC     24

// pin route codes, three bits per pin
`define CSR_RT_W         3
`define CSR_RT_HIZ       3'h0
`define CSR_RT_SQW       3'h7

// square-wave control fields
`define CSR_Q_DIV_LO     0
`define CSR_Q_BASE       4
`define CSR_Q_EN         5
`define CSR_Q_DI_LO      6
`define CSR_Q_DO_LO      8
`define CSR_SQW_RST      10'h000

`endif

/* src/csr_sync.v */
// two-flop synchroniser for a bundle of independent level inputs
// assumes each bit is an unrelated level; no word coherence is promised
`timescale 1ns/1ps
module csr_sync #(
	parameter WIDTH = 8
) (
	input  wire             clk_sys,
	input  wire             arst_n,
	input  wire [WIDTH-1:0] din,
	output reg  [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			meta <= {WIDTH{1'b0}};
			dout <= {WIDTH{1'b0}};
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

/* src/csr_sqwave.v */
// square-wave generator: base clock divided by an integer 1..16
// assumes base_tick is a one-cycle pulse per base period, base_lvl its level
`timescale 1ns/1ps
`include "csr_defs.vh"
module csr_sqwave (
	input  wire       clk_sys,
	input  wire       arst_n,
	input  wire       en,
	input  wire [3:0] div_m1,
	input  wire       base_tick,
	input  wire       base_lvl,
	output reg        sq_out
);
	reg  [3:0] phase;
	wire [4:0] divisor = {1'b0, div_m1} + 5'h01;
	// low for (d+1)/2 ticks, high for the rest
	wire [4:0] low_ticks = (divisor + 5'h01) >> 1;

	// phase walks 0..d-1, one step per base tick
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			phase  <= 4'h0;
			sq_out <= 1'b0;
		end else if (!en) begin
			phase  <= 4'h0;
			sq_out <= 1'b0;
		end else if (div_m1 == 4'h0) begin
			sq_out <= base_lvl; // divide by one passes the base through
		end else if (base_tick) begin
			phase  <= (phase == div_m1) ? 4'h0 : phase + 4'h1;
			sq_out <= ({1'b0, (phase == div_m1) ? 4'h0 : phase + 4'h1} >= low_ticks);
		end
	end
endmodule

/* src/csr_top.v */
// counter signal routing: input selectors, arming, output shaping, pin routes
// assumes all pin and timebase inputs are synchronous levels on clk_sys
// Overview of operation
// - each counter selects its count source from timebases, lines, terminals, star, compare
// - count source may also be the other counter's terminal count or gate
// - count moves up or down on the chosen edge of the source
// - gate selects from lines, terminals, analog triggers and clocks, sample clocks, events
// - gate may also be the other counter's internal output or count source
// - gate can start, stop or latch the counter as configured
// - first-edge input selects from lines, terminals, analog triggers, star, compare
// - first-edge input also takes other's output, gate, source and own gate
// - phase-B input doubles as count direction control
// - separate phase-A, phase-B and index selectors per counter
// - nothing happens until armed by software or hardware arming input; here the hardware input arms only while the software arm bit is set
// - output generation needs both arming and start trigger when both used
// - hardware arming selects lines, terminals, triggers, star, compare, other output
// - internal output pulses or toggles on terminal count, polarity selectable
// - internal output feeds counters and analog or digital timing sources; here counters, pins and digital sample clocks only
// - source, gate, output drive any terminal or line; terminals start high-impedance
// - square wave reaches terminals only, and digital in and out sample clocks
// - square wave is base clock divided by 1 to 16, base halved 20 MHz or 100 kHz
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "csr_defs.vh"
module csr_top #(
	parameter CW = 32
) (
	input  wire        clk_sys,
	input  wire        arst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        tb_80m,
	input  wire        tb_20m,
	input  wire        tb_100k,
	input  wire        bkpl_clk,
	input  wire        star_in,
	input  wire        acmp_evt,
	input  wire        ai_ref_trig,
	input  wire        ai_start_trig,
	input  wire        ai_sample_clk,
	input  wire        ai_convert_clk,
	input  wire        ao_sample_clk,
	input  wire        di_sample_clk,
	input  wire        do_sample_clk,
	input  wire        chg_det_evt,
	input  wire [7:0]  trig_bus_line_in,
	output reg  [7:0]  trig_bus_line_out,
	output reg  [7:0]  trig_bus_line_oe_n,
	input  wire [15:0] function_terminal_in,
	output reg  [15:0] function_terminal_out,
	output reg  [15:0] function_terminal_oe_n,
	output wire [1:0]  ctr_int_out,
	output wire [1:0]  ctr_tc,
	output reg         di_sclk_src,
	output reg         do_sclk_src,
	output wire        square_wave_output
);
	// synchronised inputs
	wire [37:0] raw = {chg_det_evt, do_sample_clk, di_sample_clk, ao_sample_clk,
		ai_convert_clk, ai_sample_clk, ai_start_trig, ai_ref_trig, acmp_evt, star_in,
		bkpl_clk, tb_100k, tb_20m, tb_80m, function_terminal_in, trig_bus_line_in};
	wire [37:0] s;
	csr_sync #(.WIDTH(38)) u_sync (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.din     (raw),
		.dout    (s)
	);
	wire [23:0] ext = s[23:0];
	wire s_tb80 = s[24], s_tb20 = s[25], s_tb100k = s[26], s_bkpl = s[27];
	wire s_star = s[28], s_acmp = s[29], s_airef = s[30], s_aistart = s[31];
	wire s_aisamp = s[32], s_aiconv = s[33], s_aosamp = s[34];
	wire s_disamp = s[35], s_dosamp = s[36], s_chg = s[37];

	// apb decode; always ready, unmapped addresses answer with an error
	wire acc    = psel & penable;
	wire wr     = acc & pwrite;
	wire grp    = (paddr[7:6] == 2'b00);
	wire [4:0] roff = paddr[4:0];
	reg  mapped;
	always @* begin
		mapped = 1'b0;
		if (grp && (roff <= `CSR_R_LATCH) && (roff[1:0] == 2'b00))
			mapped = 1'b1;
		if (paddr == `CSR_A_FT_LO || paddr == `CSR_A_FT_HI || paddr == `CSR_A_TRIG ||
		    paddr == `CSR_A_SQW || paddr == `CSR_A_STATUS)
			mapped = 1'b1;
	end
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	// cross-counter levels
	wire [1:0] c_src, c_gate, c_armed, c_started;
	reg  [1:0] c_out, c_tcq;
	assign ctr_int_out = c_out;
	assign ctr_tc      = c_tcq;
	wire [31:0] rd_ctr [0:1];

	genvar i;
	generate
	for (i = 0; i < 2; i = i + 1) begin : g_ctr
		localparam [7:0] BASE = (i == 0) ? 8'h00 : `CSR_CTR_STRIDE;
		wire sel_me = grp && (paddr[5] == BASE[5]);
		reg [`CSR_CTRL_W-1:0] ctl;
		reg [31:0] sela, selb;
		reg [CW-1:0] load, cnt, latch;
		reg hw_armed, started, tog, mute;
		reg [5:0] prev;

		// per-selector candidate vectors, padded to the 6-bit code space
		wire [63:0] v_src  = {32'h0, c_gate[1-i], c_tcq[1-i], s_acmp, s_star, s_bkpl,
			s_tb100k, s_tb20, s_tb80, ext};
		wire [63:0] v_gate = {28'h0, c_src[1-i], c_out[1-i], s_acmp, s_chg, s_star, s_dosamp,
			s_disamp, s_aosamp, s_aiconv, s_aisamp, s_aistart, s_airef, ext};
		wire [63:0] v_aux  = {32'h0, prev[1], c_src[1-i], c_gate[1-i], c_out[1-i],
			s_acmp, s_star, s_aistart, s_airef, ext};
		wire [63:0] v_abz  = {38'h0, s_acmp, s_star, ext};
		wire [63:0] v_arm  = {35'h0, c_out[1-i], s_acmp, s_star, s_aistart, s_airef,
			ext};
		wire l_src  = v_src[sela[`CSR_SA_SRC +: `CSR_SEL_W]];
		wire l_gate = v_gate[sela[`CSR_SA_GATE +: `CSR_SEL_W]];
		wire l_aux  = v_aux[sela[`CSR_SA_AUX +: `CSR_SEL_W]];
		wire l_arm  = v_arm[sela[`CSR_SA_ARM +: `CSR_SEL_W]];
		wire l_a    = v_abz[selb[`CSR_SB_A +: `CSR_SEL_W]];
		wire l_b    = v_abz[selb[`CSR_SB_B +: `CSR_SEL_W]];
		wire l_z    = v_abz[selb[`CSR_SB_Z +: `CSR_SEL_W]];
		wire [5:0] cur = {l_z, l_a, l_arm, l_aux, l_gate, l_src};
		// rising and falling edges, masked for one cycle after any selector write
		wire [5:0] rise = cur & ~prev & {6{~mute}};
		wire [5:0] fall = ~cur & prev & {6{~mute}};
		wire e_src  = ctl[`CSR_C_SRCFALL] ? fall[0] : rise[0];
		wire e_gate = ctl[`CSR_C_GATEFALL] ? fall[1] : rise[1];
		wire [1:0] dir   = ctl[`CSR_C_DIR_LO +: 2];
		wire [1:0] gmode = ctl[`CSR_C_GATE_LO +: 2];
		wire armed = ctl[`CSR_C_ARM] & (~ctl[`CSR_C_HWEN] | hw_armed);
		wire need_start = (gmode == `CSR_G_START) | ctl[`CSR_C_AUXEN];
		wire run = armed & (~need_start | started) &
			((gmode != `CSR_G_PAUSE) | l_gate);
		wire step = run & ((dir == `CSR_DIR_AEDGE) ? rise[4] : e_src);
		wire up = (dir == `CSR_DIR_UP) | (dir[1] & l_b);
		wire tc = step & (up ? (cnt == {CW{1'b1}}) : (cnt == {CW{1'b0}}));
		wire w_ctl  = wr & sel_me & (roff == `CSR_R_CTRL);
		wire w_sela = wr & sel_me & (roff == `CSR_R_SELA);
		wire w_selb = wr & sel_me & (roff == `CSR_R_SELB);
		wire w_load = wr & sel_me & (roff == `CSR_R_LOAD);

		assign c_src[i]     = l_src;
		assign c_gate[i]    = l_gate;
		assign c_armed[i]   = armed;
		assign c_started[i] = started;

		// software registers
		always @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				ctl  <= `CSR_CTRL_RST;
				sela <= `CSR_SELA_RST;
				selb <= `CSR_SELB_RST;
				load <= {CW{1'b0}};
				mute <= 1'b0;
			end else begin
				if (w_ctl)
					ctl <= pwdata[`CSR_CTRL_W-1:0];
				if (w_sela)
					sela <= pwdata;
				if (w_selb)
					selb <= pwdata;
				if (w_load)
					load <= pwdata[CW-1:0];
				mute <= w_sela | w_selb;
			end
		end

		// arming, start/stop, counting and output shaping
		always @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				prev     <= 6'h00;
				hw_armed <= 1'b0;
				started  <= 1'b0;
				cnt      <= {CW{1'b0}};
				latch    <= {CW{1'b0}};
				tog      <= 1'b0;
				c_out[i] <= 1'b0;
				c_tcq[i] <= 1'b0;
			end else begin
				prev <= cur;
				if (!ctl[`CSR_C_ARM]) begin
					hw_armed <= 1'b0;
					started  <= 1'b0;
				end else if (rise[3]) begin
					hw_armed <= 1'b1;
				end
				if (armed && !started) begin
					if ((gmode == `CSR_G_START && e_gate) ||
					    (ctl[`CSR_C_AUXEN] && rise[2]))
						started <= 1'b1;
				end else if (started && ctl[`CSR_C_AUXEN] && e_gate) begin
					started <= 1'b0; // second edge ends a separation measurement
					latch   <= cnt;
				end
				if (armed && gmode == `CSR_G_LATCH && e_gate)
					latch <= cnt;
				if (armed && ctl[`CSR_C_ZEN] && rise[5])
					cnt <= load;
				else if (tc)
					cnt <= up ? {CW{1'b0}} : load;
				else if (step)
					cnt <= up ? cnt + {{(CW-1){1'b0}}, 1'b1} : cnt - {{(CW-1){1'b0}}, 1'b1};
				c_tcq[i] <= tc;
				if (tc)
					tog <= ~tog;
				// pulse or toggle on terminal count, then polarity
				c_out[i] <= (ctl[`CSR_C_TOGGLE] ? (tog ^ tc) : tc) ^ ctl[`CSR_C_INVERT];
			end
		end

		// readback for this counter's group
		assign rd_ctr[i] = (roff == `CSR_R_CTRL)  ? {{(32-`CSR_CTRL_W){1'b0}}, ctl} :
		                   (roff == `CSR_R_SELA)  ? sela :
		                   (roff == `CSR_R_SELB)  ? selb :
		                   (roff == `CSR_R_LOAD)  ? load :
		                   (roff == `CSR_R_COUNT) ? cnt :
		                   (roff == `CSR_R_LATCH) ? latch : 32'h0000_0000;
	end
	endgenerate

	// shared routing registers
	reg [31:0] ft_lo, ft_hi, trig_rt;
	reg [9:0]  sqw_ctl;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ft_lo   <= 32'h0000_0000;
			ft_hi   <= 32'h0000_0000;
			trig_rt <= 32'h0000_0000;
			sqw_ctl <= `CSR_SQW_RST;
		end else if (wr) begin
			if (paddr == `CSR_A_FT_LO)
				ft_lo <= pwdata;
			if (paddr == `CSR_A_FT_HI)
				ft_hi <= pwdata;
			if (paddr == `CSR_A_TRIG)
				trig_rt <= pwdata;
			if (paddr == `CSR_A_SQW)
				sqw_ctl <= pwdata[9:0];
		end
	end

	// square-wave base: halved 20 MHz tick or 100 kHz tick
	reg tb20_q, tb100_q, half;
	wire tb20_rise  = s_tb20 & ~tb20_q;
	wire tb100_rise = s_tb100k & ~tb100_q;
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tb20_q  <= 1'b0;
			tb100_q <= 1'b0;
			half    <= 1'b0;
		end else begin
			tb20_q  <= s_tb20;
			tb100_q <= s_tb100k;
			if (tb20_rise)
				half <= ~half;
		end
	end
	wire base_sel  = sqw_ctl[`CSR_Q_BASE];
	wire base_tick = base_sel ? tb100_rise : (tb20_rise & half);
	wire base_lvl  = base_sel ? s_tb100k : half;
	csr_sqwave u_sqw (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.en        (sqw_ctl[`CSR_Q_EN]),
		.div_m1    (sqw_ctl[`CSR_Q_DIV_LO +: 4]),
		.base_tick (base_tick),
		.base_lvl  (base_lvl),
		.sq_out    (square_wave_output)
	);

	// pin drivers; route code picks a counter signal or the square wave
	wire [7:0] rt_lvl = {square_wave_output, c_out[1], c_gate[1], c_src[1],
		c_out[0], c_gate[0], c_src[0], 1'b0};
	wire [47:0] ft_codes = {ft_hi[23:0], ft_lo[23:0]};
	genvar p;
	generate
	for (p = 0; p < 16; p = p + 1) begin : g_ft
		wire [2:0] code = ft_codes[p*`CSR_RT_W +: `CSR_RT_W];
		always @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				function_terminal_out[p]  <= 1'b0;
				function_terminal_oe_n[p] <= 1'b1; // high-impedance from startup
			end else begin
				function_terminal_out[p]  <= rt_lvl[code];
				function_terminal_oe_n[p] <= (code == `CSR_RT_HIZ);
			end
		end
	end
	for (p = 0; p < 8; p = p + 1) begin : g_trig
		wire [2:0] code = trig_rt[p*`CSR_RT_W +: `CSR_RT_W];
		// square wave is not allowed onto trigger lines
		wire drive = (code != `CSR_RT_HIZ) && (code != `CSR_RT_SQW);
		always @(posedge clk_sys or negedge arst_n) begin
			if (!arst_n) begin
				trig_bus_line_out[p]  <= 1'b0;
				trig_bus_line_oe_n[p] <= 1'b1;
			end else begin
				trig_bus_line_out[p]  <= drive & rt_lvl[code];
				trig_bus_line_oe_n[p] <= ~drive;
			end
		end
	end
	endgenerate

	// digital sample clock sources: none, counter outputs or square wave
	wire [3:0] sclk_lvl = {square_wave_output, c_out[1], c_out[0], 1'b0};
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			di_sclk_src <= 1'b0;
			do_sclk_src <= 1'b0;
		end else begin
			di_sclk_src <= sclk_lvl[sqw_ctl[`CSR_Q_DI_LO +: 2]];
			do_sclk_src <= sclk_lvl[sqw_ctl[`CSR_Q_DO_LO +: 2]];
		end
	end

	// read data is captured in the setup cycle and held through access
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (paddr)
				`CSR_A_FT_LO:  prdata <= {8'h00, ft_lo[23:0]};
				`CSR_A_FT_HI:  prdata <= {8'h00, ft_hi[23:0]};
				`CSR_A_TRIG:   prdata <= {8'h00, trig_rt[23:0]};
				`CSR_A_SQW:    prdata <= {22'h000000, sqw_ctl};
				`CSR_A_STATUS: prdata <= {25'h0000000, square_wave_output, c_started,
					c_out, c_armed};
				default:       prdata <= (mapped && grp) ? rd_ctr[paddr[5]] : 32'h0000_0000;
			endcase
		end
	end
endmodule

/* bench/csr_monitor.sv */
// checker for the routing block: apb answers, pin enables, counter outputs
// assumes it is bound onto csr_top and sees only that module's ports
`timescale 1ns/1ps
module csr_monitor (
	input wire        clk_sys,
	input wire        arst_n,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [7:0]  trig_bus_line_oe_n,
	input wire [15:0] function_terminal_oe_n,
	input wire [1:0]  ctr_int_out,
	input wire [1:0]  ctr_tc
);
	logic cfg_seen;
	wire  wr_acc = psel && penable && pwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_tc_blip;
		ctr_tc[0] ##1 !ctr_tc[0];
	endsequence
	// until software writes something, nothing may move or drive
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			cfg_seen <= 1'b0;
		else if (wr_acc)
			cfg_seen <= 1'b1;
	end
	apb_ready_a: assert property (s_access |-> pready)
		else $error("pready low in access phase");
	err_in_access_a: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	unmapped_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
		else $error("refused read returned data");
	rdata_hold_a: assert property (s_access |=> $stable(prdata))
		else $error("read data moved after access");
	idle_unarmed_a: assert property (!cfg_seen |-> ctr_tc == 2'b00 && ctr_int_out == 2'b00)
		else $error("counter output moved before any setup");
	pins_hiz_a: assert property (!cfg_seen |-> function_terminal_oe_n == 16'hFFFF && trig_bus_line_oe_n == 8'hFF)
		else $error("pin driven before any routing");
	oe_by_write_a: assert property ($changed({trig_bus_line_oe_n, function_terminal_oe_n}) |-> $past(wr_acc) || $past(wr_acc, 2))
		else $error("pin enable changed without a write");
	tc_single_a: assert property (ctr_tc[0] |-> s_tc_blip)
		else $error("terminal count longer than one cycle");
	out_follows_tc_a: assert property ($changed(ctr_int_out) |-> (|(ctr_tc | $past(ctr_tc))) || $past(wr_acc) || $past(wr_acc, 2))
		else $error("internal output moved without terminal count");
endmodule

bind csr_top csr_monitor u_mon (.clk_sys, .arst_n, .psel, .penable, .pwrite, .prdata,
	.pready, .pslverr, .trig_bus_line_oe_n, .function_terminal_oe_n, .ctr_int_out, .ctr_tc);

/* bench/csr_pads.sv */
// far side model: timebases, event sources and terminal pads
// assumes clk_sys at 25 MHz; the bench drives pads through pad_en and pad_val
`timescale 1ns/1ps
module csr_pads (
	input  wire         clk_sys,
	input  wire  [15:0] pad_val,
	input  wire  [15:0] pad_en,
	input  wire  [15:0] ft_out,
	input  wire  [15:0] ft_oe_n,
	output logic [15:0] ft_in,
	output logic [18:0] misc,
	output logic        tb_fast,
	output logic        tb_100k
);
	logic [15:0] last = 16'h0000;
	logic [6:0]  div = 7'h00;
	initial begin
		misc = 19'h00000;
		tb_fast = 1'b0;
		tb_100k = 1'b0;
	end
	// 100 kHz is 250 clocks, so toggle every 125; events just wander
	always @(posedge clk_sys) begin
		last <= ft_in;
		misc <= misc + 19'h00001;
		tb_fast <= !tb_fast;
		div <= (div == 7'h7C) ? 7'h00 : div + 7'h01;
		if (div == 7'h7C)
			tb_100k <= !tb_100k;
	end
	// design drive wins; a released pad wanders so stale data never matches
	always_comb begin
		for (int i = 0; i < 16; i++)
			ft_in[i] = !ft_oe_n[i] ? ft_out[i] : (pad_en[i] ? pad_val[i] : !last[i]);
	end
endmodule

/* bench/test_counter_signal_routing.sv */
// self-checking bench: apb setup, pad edges, routing and square-wave checks
// assumes csr_pads models the far side and csr_monitor is bound to uut
`timescale 1ns/1ps
`include "csr_defs.vh"
module test_counter_signal_routing;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [15:0] pad_val = 16'h0000;
	logic [15:0] pad_en = 16'h0001;
	logic [31:0] rd;
	logic        slv;
	logic        io_last = 1'b0;
	int          err_total = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          tc0 = 0;
	int          io_rise = 0;
	logic [7:0]  zr [13] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28,
		8'h40, 8'h44, 8'h48, 8'h4C, 8'h50};
	wire  [31:0] prdata;
	wire  [18:0] misc;
	wire  [15:0] function_terminal_in, function_terminal_out, function_terminal_oe_n;
	wire  [7:0]  trig_bus_line_in, trig_bus_line_out, trig_bus_line_oe_n;
	wire  [1:0]  ctr_int_out, ctr_tc;
	wire         pready, pslverr, tb_fast, tb_100k, bkpl_clk, star_in, acmp_evt;
	wire         ai_ref_trig, ai_start_trig, ai_sample_clk, ai_convert_clk, ao_sample_clk;
	wire         di_sample_clk, do_sample_clk, chg_det_evt, di_sclk_src, do_sclk_src;
	wire         square_wave_output;
	wire  [1:0]  probe = {function_terminal_out[1], di_sclk_src};
	assign {trig_bus_line_in, star_in, acmp_evt, ai_ref_trig, ai_start_trig, ai_sample_clk,
		ai_convert_clk, ao_sample_clk, di_sample_clk, do_sample_clk, chg_det_evt, bkpl_clk} = misc;
	always #20 clk_sys = !clk_sys;
	csr_top uut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .tb_80m(tb_fast), .tb_20m(tb_fast), .tb_100k, .bkpl_clk, .star_in,
		.acmp_evt, .ai_ref_trig, .ai_start_trig, .ai_sample_clk, .ai_convert_clk,
		.ao_sample_clk, .di_sample_clk, .do_sample_clk, .chg_det_evt, .trig_bus_line_in,
		.trig_bus_line_out, .trig_bus_line_oe_n, .function_terminal_in, .function_terminal_out,
		.function_terminal_oe_n, .ctr_int_out, .ctr_tc, .di_sclk_src, .do_sclk_src,
		.square_wave_output);
	csr_pads u_pads (.clk_sys, .pad_val, .pad_en, .ft_out(function_terminal_out),
		.ft_oe_n(function_terminal_oe_n), .ft_in(function_terminal_in), .misc, .tb_fast,
		.tb_100k);
	task automatic summarize;
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// setup cycle, then access until pready; nothing released before that edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk("prdata", e, rd);
	endtask
	// slow pulses on pad 0 so every edge survives the synchronisers
	task automatic edges(input int n);
		repeat (n) begin
			pad_val[0] <= 1'b1;
			repeat (4) @(posedge clk_sys);
			pad_val[0] <= 1'b0;
			repeat (4) @(posedge clk_sys);
		end
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic period(input int k, input logic [31:0] e);
		time t0;
		@(posedge probe[k]);
		t0 = $time;
		@(posedge probe[k]);
		chk("period", e, 32'(($time - t0) / 40));
	endtask
	// watchdog plus terminal count and output pulse tallies
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		io_last <= ctr_int_out[0];
		if (ctr_tc[0] === 1'b1)
			tc0 <= tc0 + 1;
		if (ctr_int_out[0] === 1'b1 && io_last === 1'b0)
			io_rise <= io_rise + 1;
		if (cycles == 32'h00004E20) begin
			chk("watchdog", 32'h00000000, 32'h00000001);
			summarize();
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		chk("ft_oe_n", 32'h0000FFFF, {16'h0000, function_terminal_oe_n});
		foreach (zr[i])
			rchk(zr[i], 32'h00000000);
		apb(1'b1, `CSR_R_COUNT, 32'h00000005);
		rchk(`CSR_R_COUNT, 32'h00000000);
		apb(1'b0, 8'h60, 32'h00000000);
		chk("pslverr", 32'h00000001, {31'h0, slv});
		apb(1'b1, `CSR_R_SELB, 32'h00190817);
		rchk(`CSR_R_SELB, 32'h00190817);
		apb(1'b1, `CSR_R_SELA, 32'h00000008);
		rchk(`CSR_R_SELA, 32'h00000008);
		edges(3);
		rchk(`CSR_R_COUNT, 32'h00000000);
		apb(1'b1, `CSR_R_CTRL, 32'h00000001);
		edges(3);
		rchk(`CSR_R_COUNT, 32'h00000003);
		apb(1'b1, `CSR_R_LOAD, 32'h00000002);
		apb(1'b1, `CSR_R_CTRL, 32'h00000009);
		apb(1'b1, `CSR_CTR_STRIDE + `CSR_R_SELA, 32'h0000001E);
		apb(1'b1, `CSR_CTR_STRIDE + `CSR_R_CTRL, 32'h00000001);
		edges(4);
		rchk(`CSR_R_COUNT, 32'h00000002);
		rchk(`CSR_CTR_STRIDE + `CSR_R_COUNT, 32'h00000001);
		chk("tc0", 32'h00000001, 32'(tc0));
		chk("io_rise", 32'h00000001, 32'(io_rise));
		apb(1'b1, `CSR_R_CTRL, 32'h00000109);
		apb(1'b1, `CSR_A_FT_LO, 32'h000000F8);
		apb(1'b1, `CSR_A_TRIG, 32'h0000000F);
		pad_val[0] <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chk("ctr_out", 32'h00000001, {30'h0, ctr_int_out});
		chk("ft_oe_n", 32'h0000FFF9, {16'h0000, function_terminal_oe_n});
		chk("ft_out2", 32'h00000001, {31'h0, function_terminal_out[2]});
		chk("trig_oe_n", 32'h000000FD, {24'h0, trig_bus_line_oe_n});
		chk("trig_out1", 32'h00000001, {31'h0, trig_bus_line_out[1]});
		apb(1'b1, `CSR_A_SQW, 32'h000001F3);
		period(0, 32'h000003E8);
		period(1, 32'h000003E8);
		chk("do_sclk", 32'h00000001, {31'h0, do_sclk_src});
		// counter 1: source pad 0, hardware arm on pad 15, direction from pad 14
		pad_en <= 16'hC001;
		pad_val[15:14] <= 2'b01;
		apb(1'b1, `CSR_CTR_STRIDE + `CSR_R_CTRL, 32'h00000000);
		apb(1'b1, `CSR_CTR_STRIDE + `CSR_R_SELA, 32'h17000008);
		apb(1'b1, `CSR_CTR_STRIDE + `CSR_R_SELB, 32'h00001600);
		apb(1'b1, `CSR_CTR_STRIDE + `CSR_R_CTRL, 32'h00000013);
		edges(2);
		rchk(`CSR_CTR_STRIDE + `CSR_R_COUNT, 32'h00000001);
		pad_val[15] <= 1'b1;
		repeat (4) @(posedge clk_sys);
		edges(2);
		rchk(`CSR_CTR_STRIDE + `CSR_R_COUNT, 32'h00000003);
		pad_val[14] <= 1'b0;
		repeat (4) @(posedge clk_sys);
		edges(1);
		rchk(`CSR_CTR_STRIDE + `CSR_R_COUNT, 32'h00000002);
		summarize();
	end
endmodule
